/* hw/fdbp_pkg.sv */
// Constants, carriers and state layout of the dual-bus data port
package fdbp_pkg;
	localparam int DW = 10;
	localparam int AW = 8;
	localparam logic [AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [AW-1:0] OFS_STATUS = 8'h04;
	localparam logic [AW-1:0] OFS_TXCNT = 8'h08;
	localparam int CTRL_SPI_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_SYSCLK_BIT = 3;
	localparam int STAT_DIR_BIT = 3;
	localparam int STAT_STRAP_BIT = 4;
	localparam int STAT_WIDTH_BIT = 5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_PERIOD_NS = 4;
	localparam int DCLK_DELAY_NS = 8;
	localparam int DCLK_DELAY_CYC = (DCLK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] DCLK_DELAY = 2'(DCLK_DELAY_CYC);
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	localparam logic [DW-1:0] ALL_ON = 10'h3FF;
	localparam logic [DW-1:0] MSB_ON = 10'h200;

	typedef enum logic [1:0] {MODE_FD, MODE_HALF_DUPLEX_INTERLEAVED_MODE, MODE_HALF_DUPLEX_PARALLEL_MODE, MODE_CLONE} fdbp_mode_type;

	typedef struct packed {
		logic [DW-1:0] data;
		logic [DW-1:0] oe;
	} fdbp_bus_drv_type;

	typedef struct packed {
		logic [DW-1:0] a;
		logic [DW-1:0] b;
		logic valid;
	} fdbp_tx_pair_type;

	typedef struct packed {
		logic awvalid;
		logic [AW-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [AW-1:0] araddr;
		logic rready;
	} fdbp_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} fdbp_axi_rsp_type;

	typedef struct packed {
		logic [1:0] strap_sync;
		logic [1:0] strap_cnt;
		logic strap_done;
		logic strap_fd;
		logic [1:0] sclk_sync;
		logic sclk_prev;
		logic [1:0] dir_sync;
		logic [1:0] width_sync;
		logic [DW-1:0] up_sync1;
		logic [DW-1:0] up_sync2;
		logic [DW-1:0] lo_sync1;
		logic [DW-1:0] lo_sync2;
		logic cfg_spi;
		fdbp_mode_type cfg_mode;
		logic cfg_sysclk;
		logic [1:0] dclk_cnt;
		logic dclk;
		logic [DW-1:0] rx_b_hold;
		logic [DW-1:0] tx_a_hold;
		logic tx_a_seen;
		logic [15:0] tx_pairs;
		fdbp_bus_drv_type up_drv;
		fdbp_bus_drv_type lo_drv;
		logic width_out;
		logic width_oe;
		fdbp_tx_pair_type tx;
		logic aw_have;
		logic [AW-1:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		fdbp_axi_rsp_type rsp;
	} fdbp_state_type;

	function automatic logic fdbp_rx_interleaved(input fdbp_mode_type m);
		fdbp_rx_interleaved = (m == MODE_FD) || (m == MODE_HALF_DUPLEX_INTERLEAVED_MODE);
	endfunction

	function automatic logic fdbp_tx_interleaved(input fdbp_mode_type m);
		fdbp_tx_interleaved = (m != MODE_HALF_DUPLEX_PARALLEL_MODE);
	endfunction
endpackage

/* hw/fdbp_port.sv */
// Dual-bus flexible data port with AXI4-Lite configuration registers
// How it works
// - Two rx, two tx 10-bit channels, two buses.
// - Only full duplex runs tx and rx together.
// - Full duplex: upper tx in, lower rx out.
// - Interleaved tx outside full duplex: lower MSB is tx marker.
// - Half duplex interleaved rx: upper MSB drives rx marker.
// - Parallel tx: upper channel A, lower B.
// - Parallel rx: upper channel B, lower A.
// - Register config turns width pin into sysclk.
// - Compatibility mode reachable only by register.
// - Compatibility: interleaved tx, parallel rx.
// - Parallel rx: one word per channel per sample.
// - Interleaved rx: words at twice sample rate.
// - Half duplex direction pin: high tx, low rx.
// - Rx marker low for A, high for B.
// - Half duplex floats the unused bus.
// - Mode strap latched once after reset release.
`timescale 1ns/1ns
module fdbp_port
	import fdbp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire fdbp_axi_req_type axi_req,
	output fdbp_axi_rsp_type axi_rsp,
	input wire logic sample_clk,
	input wire logic mode_strap_fd,
	input wire logic direction_select_pin,
	input wire logic width_or_sysclk_level,
	output logic width_or_sysclk_out,
	output logic width_or_sysclk_oe,
	input wire logic [DW-1:0] upper_data_bus_level,
	output fdbp_bus_drv_type upper_data_bus_drv,
	input wire logic [DW-1:0] lower_data_bus_level,
	output fdbp_bus_drv_type lower_data_bus_drv,
	output logic data_clock_out_pin,
	input wire logic [DW-1:0] rx_a_data,
	input wire logic [DW-1:0] rx_b_data,
	output fdbp_tx_pair_type tx_word
);
	fdbp_state_type s_q;
	fdbp_state_type s_d;
	fdbp_mode_type mode_eff;
	logic dir_tx;
	logic tx_act;
	logic rx_act;
	logic sclk_rise;
	logic sclk_fall;
	logic tx_ev;
	logic rx_ev;
	logic tx_mark;
	logic [31:0] rd_val;
	logic rd_ok;

	// Pins can never select the compatibility mode
	assign mode_eff = s_q.cfg_spi ? s_q.cfg_mode :
		(s_q.strap_fd ? MODE_FD : (s_q.width_sync[1] ? MODE_HALF_DUPLEX_INTERLEAVED_MODE : MODE_HALF_DUPLEX_PARALLEL_MODE));
	assign dir_tx = s_q.dir_sync[1];
	// Half duplex picks one direction by the pin; full duplex runs both
	assign tx_act = (mode_eff == MODE_FD) || dir_tx;
	assign rx_act = (mode_eff == MODE_FD) || !dir_tx;
	assign sclk_rise = s_q.sclk_sync[1] && !s_q.sclk_prev;
	assign sclk_fall = !s_q.sclk_sync[1] && s_q.sclk_prev;
	// Interleaved paths move a word on both sample clock edges
	assign tx_ev = tx_act && (sclk_rise || (fdbp_tx_interleaved(mode_eff) && sclk_fall));
	assign rx_ev = rx_act && (sclk_rise || (fdbp_rx_interleaved(mode_eff) && sclk_fall));
	// Marker pin: the direction pin in full duplex, lower MSB otherwise
	assign tx_mark = (mode_eff == MODE_FD) ? s_q.dir_sync[1] : s_q.lo_sync2[DW-1];

	always_comb
	begin
		rd_ok = 1'b1;
		case (s_q.awaddr)
			default:
			begin
				rd_val = 32'h0;
			end
		endcase
		case (axi_req.araddr)
			OFS_CTRL:
			begin
				rd_val = {28'h0, s_q.cfg_sysclk, s_q.cfg_mode, s_q.cfg_spi};
			end
			OFS_STATUS:
			begin
				rd_val = {26'h0, s_q.width_sync[1], s_q.strap_fd, dir_tx, mode_eff, s_q.cfg_spi};
			end
			OFS_TXCNT:
			begin
				rd_val = {16'h0, s_q.tx_pairs};
			end
			default:
			begin
				rd_val = 32'h0;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		s_d = s_q;
		// Pin synchronisers, two stages each
		s_d.strap_sync = {s_q.strap_sync[0], mode_strap_fd};
		s_d.sclk_sync = {s_q.sclk_sync[0], sample_clk};
		s_d.sclk_prev = s_q.sclk_sync[1];
		s_d.dir_sync = {s_q.dir_sync[0], direction_select_pin};
		s_d.width_sync = {s_q.width_sync[0], width_or_sysclk_level};
		s_d.up_sync1 = upper_data_bus_level;
		s_d.up_sync2 = s_q.up_sync1;
		s_d.lo_sync1 = lower_data_bus_level;
		s_d.lo_sync2 = s_q.lo_sync1;

		// Strap caught once the synchroniser has settled, then frozen
		if (!s_q.strap_done)
		begin
			s_d.strap_cnt = s_q.strap_cnt + 2'h1;
			if (s_q.strap_cnt == STRAP_WAIT)
			begin
				s_d.strap_fd = s_q.strap_sync[1];
				s_d.strap_done = 1'b1;
			end
		end

		// Data clock drops with each new word, rises once it has settled
		s_d.tx.valid = 1'b0;
		if (tx_ev || rx_ev)
		begin
			s_d.dclk = 1'b0;
			s_d.dclk_cnt = DCLK_DELAY;
		end
		else if (s_q.dclk_cnt != 2'h0)
		begin
			s_d.dclk_cnt = s_q.dclk_cnt - 2'h1;
			if (s_q.dclk_cnt == 2'h1)
			begin
				s_d.dclk = 1'b1;
			end
		end

		if (tx_ev)
		begin
			if (fdbp_tx_interleaved(mode_eff))
			begin
				// Word and marker sampled together; high marker means channel A
				if (tx_mark)
				begin
					s_d.tx_a_hold = s_q.up_sync2;
					s_d.tx_a_seen = 1'b1;
				end
				else if (s_q.tx_a_seen)
				begin
					s_d.tx = '{a: s_q.tx_a_hold, b: s_q.up_sync2, valid: 1'b1};
					s_d.tx_a_seen = 1'b0;
					s_d.tx_pairs = s_q.tx_pairs + 16'h1;
				end
			end
			else
			begin
				s_d.tx = '{a: s_q.up_sync2, b: s_q.lo_sync2, valid: 1'b1};
				s_d.tx_pairs = s_q.tx_pairs + 16'h1;
			end
		end

		if (rx_ev)
		begin
			if (fdbp_rx_interleaved(mode_eff))
			begin
				// Channel A with low marker on rise, held B with high marker on fall
				if (sclk_rise)
				begin
					s_d.lo_drv.data = rx_a_data;
					s_d.rx_b_hold = rx_b_data;
					s_d.up_drv.data[DW-1] = 1'b0;
				end
				else
				begin
					s_d.lo_drv.data = s_q.rx_b_hold;
					s_d.up_drv.data[DW-1] = 1'b1;
				end
			end
			else
			begin
				s_d.up_drv.data = rx_b_data;
				s_d.lo_drv.data = rx_a_data;
			end
		end

		// Lower bus drives whenever rx runs; upper only as rx bus or marker
		s_d.lo_drv.oe = rx_act ? ALL_ON : '0;
		if (!rx_act || mode_eff == MODE_FD)
		begin
			s_d.up_drv.oe = '0;
		end
		else
		begin
			s_d.up_drv.oe = (mode_eff == MODE_HALF_DUPLEX_INTERLEAVED_MODE) ? MSB_ON : ALL_ON;
		end

		// Width pin: sysclk under register config, data clock in strapped full duplex
		if (s_q.cfg_spi)
		begin
			s_d.width_oe = (mode_eff == MODE_FD) || s_q.cfg_sysclk;
			s_d.width_out = s_q.sclk_sync[1];
		end
		else
		begin
			s_d.width_oe = (mode_eff == MODE_FD);
			s_d.width_out = s_q.dclk;
		end

		// AXI4-Lite write: address and data taken in either order
		if (axi_req.awvalid && s_q.rsp.awready)
		begin
			s_d.aw_have = 1'b1;
			s_d.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s_q.rsp.wready)
		begin
			s_d.w_have = 1'b1;
			s_d.wdata = axi_req.wdata;
			s_d.wstrb = axi_req.wstrb;
		end
		if (s_q.rsp.bvalid && axi_req.bready)
		begin
			s_d.rsp.bvalid = 1'b0;
		end
		if (s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid)
		begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.rsp.bvalid = 1'b1;
			s_d.rsp.bresp = RESP_OKAY;
			if (s_q.awaddr == OFS_CTRL)
			begin
				if (s_q.wstrb[0])
				begin
					s_d.cfg_spi = s_q.wdata[CTRL_SPI_BIT];
					s_d.cfg_mode = fdbp_mode_type'(s_q.wdata[CTRL_MODE_LSB +: 2]);
					s_d.cfg_sysclk = s_q.wdata[CTRL_SYSCLK_BIT];
				end
			end
			else if (s_q.awaddr != OFS_STATUS && s_q.awaddr != OFS_TXCNT)
			begin
				s_d.rsp.bresp = RESP_SLVERR;
			end
		end
		s_d.rsp.awready = !s_d.aw_have && !s_d.rsp.bvalid;
		s_d.rsp.wready = !s_d.w_have && !s_d.rsp.bvalid;

		// AXI4-Lite read: one outstanding, answer one edge after address
		if (s_q.rsp.rvalid && axi_req.rready)
		begin
			s_d.rsp.rvalid = 1'b0;
		end
		if (axi_req.arvalid && s_q.rsp.arready)
		begin
			s_d.rsp.rvalid = 1'b1;
			s_d.rsp.rdata = rd_val;
			s_d.rsp.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		s_d.rsp.arready = !s_d.rsp.rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign axi_rsp = s_q.rsp;
	assign width_or_sysclk_out = s_q.width_out;
	assign width_or_sysclk_oe = s_q.width_oe;
	assign upper_data_bus_drv = s_q.up_drv;
	assign lower_data_bus_drv = s_q.lo_drv;
	assign data_clock_out_pin = s_q.dclk;
	assign tx_word = s_q.tx;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_fd_upper_float: assert property (mode_eff == MODE_FD |=> upper_data_bus_drv.oe == '0)
		else $error("upper bus driven in full duplex");
	a_tx_buses_float: assert property (mode_eff != MODE_FD && dir_tx |=>
		upper_data_bus_drv.oe == '0 && lower_data_bus_drv.oe == '0)
		else $error("bus driven during half duplex transmit");
	a_rx_lower_drive: assert property (rx_act |=> lower_data_bus_drv.oe == ALL_ON)
		else $error("lower bus not driven during receive");
	a_clone_pins: assert property (!s_q.cfg_spi |-> mode_eff != MODE_CLONE)
		else $error("compatibility mode reached from pins");
	a_strap_hold: assert property (s_q.strap_done |=> s_q.strap_done && $stable(s_q.strap_fd))
		else $error("latched strap changed");
	a_sysclk_fd: assert property (s_q.cfg_spi && mode_eff == MODE_FD |=> width_or_sysclk_oe)
		else $error("sysclk not driven in full duplex");
	// Clock stays low two cycles so the word settles before the rising edge
	a_dclk_shape: assert property (tx_ev || rx_ev |=>
		!data_clock_out_pin [*2] ##1 data_clock_out_pin)
		else $error("data clock not low then high after a word");
	a_rx_marker: assert property (rx_ev && mode_eff == MODE_HALF_DUPLEX_INTERLEAVED_MODE |=>
		upper_data_bus_drv.data[DW-1] == $past(sclk_fall))
		else $error("rx marker level wrong");
	a_rx_parallel: assert property (rx_ev && !fdbp_rx_interleaved(mode_eff) |=>
		lower_data_bus_drv.data == $past(rx_a_data) && upper_data_bus_drv.data == $past(rx_b_data))
		else $error("parallel rx words wrong");
	a_tx_parallel: assert property (tx_ev && mode_eff == MODE_HALF_DUPLEX_PARALLEL_MODE |=>
		tx_word.valid && tx_word.a == $past(s_q.up_sync2) && tx_word.b == $past(s_q.lo_sync2))
		else $error("parallel tx pair wrong");
	a_tx_pulse: assert property (tx_word.valid |=> !tx_word.valid)
		else $error("tx valid longer than one cycle");

	// Interleaved rx: rising half carries channel A straight from the converter
	a_rx_inter_a: assert property (rx_ev && sclk_rise && fdbp_rx_interleaved(mode_eff) |=>
		lower_data_bus_drv.data == $past(rx_a_data))
		else $error("interleaved rx channel A word wrong");
	// Only the marker bit of the upper bus may drive in interleaved receive
	a_half_duplex_interleaved_mode_marker_oe: assert property (rx_act && mode_eff == MODE_HALF_DUPLEX_INTERLEAVED_MODE |=>
		upper_data_bus_drv.oe == MSB_ON)
		else $error("upper bus drive wrong in interleaved receive");
	// Every delivered pair is counted exactly once
	a_tx_pair_count: assert property (tx_word.valid |->
		s_q.tx_pairs == $past(s_q.tx_pairs) + 16'h1)
		else $error("tx pair count not advanced");
	// Read answer is fixed at one cycle; software may rely on it
	a_rd_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read answer late");

	c_fd_pair: cover property (mode_eff == MODE_FD && tx_word.valid);
	c_half_duplex_parallel_mode_rx: cover property (mode_eff == MODE_HALF_DUPLEX_PARALLEL_MODE && rx_ev);
	c_clone_tx: cover property (mode_eff == MODE_CLONE && tx_word.valid);
	c_write: cover property (axi_rsp.bvalid && axi_req.bready);
	c_half_duplex_interleaved_mode_rx: cover property (mode_eff == MODE_HALF_DUPLEX_INTERLEAVED_MODE && rx_ev);
endmodule

/* sim/fdbp_proc_model.sv */
// Behavioural baseband processor on the far side of the data buses
`timescale 1ns/1ns
module fdbp_proc_model
	import fdbp_pkg::*;
(
	input wire logic aclk,
	input wire logic sample_clk,
	input wire logic tx_on,
	input wire logic inter,
	input wire fdbp_bus_drv_type up_drv,
	input wire fdbp_bus_drv_type lo_drv,
	output logic [DW-1:0] up_lvl,
	output logic [DW-1:0] lo_lvl,
	output logic [DW-1:0] cur_a,
	output logic [DW-1:0] cur_b
);
	logic a_ph;
	logic flt;
	logic [DW-1:0] up_p, lo_p, p_oe, fl;
	initial
	begin
		a_ph = 1'b0;
		flt = 1'b0;
		cur_a = '0;
		cur_b = '0;
	end
	// Released lines toggle so a stale level can never pass
	always @(posedge aclk) flt <= ~flt;
	// Mid-phase updates keep a word stable across the edge that samples it
	always @(sample_clk)
	begin
		#31;
		@(posedge aclk);
		if (!sample_clk)
		begin
			a_ph <= 1'b1;
			cur_a <= DW'($urandom);
			if (!inter) cur_b <= DW'($urandom);
		end
		else
		begin
			a_ph <= 1'b0;
			if (inter) cur_b <= DW'($urandom);
		end
	end
	always_comb
	begin
		up_p = (inter && !a_ph) ? cur_b : cur_a;
		lo_p = inter ? {a_ph, {(DW-1){1'b0}}} : cur_b;
		p_oe = inter ? MSB_ON : ALL_ON;
		fl = {DW{flt}};
		up_lvl = (up_drv.oe & up_drv.data) | (~up_drv.oe & (tx_on ? up_p : fl));
		lo_lvl = (lo_drv.oe & lo_drv.data) | (~lo_drv.oe & (tx_on ? ((p_oe & lo_p) | (~p_oe & fl)) : fl));
	end
endmodule

/* sim/flexible_dual_bus_data_port_test.sv */
// Self-checking bench for the dual-bus data port
`timescale 1ns/1ns
module flexible_dual_bus_data_port_test
	import fdbp_pkg::*;
();
	logic aclk, aresetn, sample_clk, strap, dir, width_sel, w_out, w_oe, dclk;
	fdbp_axi_req_type axi_req;
	fdbp_axi_rsp_type axi_rsp;
	logic [DW-1:0] up_lvl, lo_lvl, rx_a, rx_b, cur_a, cur_b;
	fdbp_bus_drv_type up_drv, lo_drv;
	fdbp_tx_pair_type tx_word;
	int miscompares = 0;
	int check_count = 0;
	int vcount = 0;
	int seed_v, v0;
	logic [31:0] d, c0;
	logic [1:0] r;
	fdbp_port uut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
		.sample_clk(sample_clk), .mode_strap_fd(strap), .direction_select_pin(dir),
		.width_or_sysclk_level(w_oe ? w_out : width_sel), .width_or_sysclk_out(w_out),
		.width_or_sysclk_oe(w_oe), .upper_data_bus_level(up_lvl), .upper_data_bus_drv(up_drv),
		.lower_data_bus_level(lo_lvl), .lower_data_bus_drv(lo_drv),
		.data_clock_out_pin(dclk), .rx_a_data(rx_a), .rx_b_data(rx_b), .tx_word(tx_word));
	fdbp_proc_model partner (.aclk(aclk), .sample_clk(sample_clk), .tx_on(dir),
		.inter(width_sel), .up_drv(up_drv), .lo_drv(lo_drv), .up_lvl(up_lvl),
		.lo_lvl(lo_lvl), .cur_a(cur_a), .cur_b(cur_b));
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Link clock runs free, unrelated in phase to aclk
	initial
	begin
		sample_clk = 1'b0;
		#1;
		forever
		begin
			#62 sample_clk = 1'b1;
			#63 sample_clk = 1'b0;
		end
	end
	always @(posedge aclk) if (tx_word.valid === 1'b1) vcount++;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		axi_req.awaddr <= a;
		axi_req.awvalid <= 1'b1;
		axi_req.wdata <= v;
		axi_req.wstrb <= 4'hF;
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (axi_rsp.awready === 1'b1 && !ad)
			begin
				ad = 1'b1;
				axi_req.awvalid <= 1'b0;
			end
			if (axi_rsp.wready === 1'b1 && !wd)
			begin
				wd = 1'b1;
				axi_req.wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (axi_rsp.bvalid !== 1'b1);
		resp = axi_rsp.bresp;
		axi_req.bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		do @(posedge aclk); while (axi_rsp.arready !== 1'b1);
		axi_req.arvalid <= 1'b0;
		do @(posedge aclk); while (axi_rsp.rvalid !== 1'b1);
		v = axi_rsp.rdata;
		resp = axi_rsp.rresp;
		axi_req.rready <= 1'b0;
	endtask
	task automatic do_reset(input logic s);
		@(posedge aclk);
		aresetn <= 1'b0;
		strap <= s;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		cyc(12);
	endtask
	task automatic rx_run(input logic il, input int n);
		logic [DW-1:0] ea, eb;
		@(negedge sample_clk);
		@(posedge aclk);
		ea = DW'($urandom);
		eb = DW'($urandom);
		rx_a <= ea;
		rx_b <= eb;
		repeat (n)
		begin
			@(posedge sample_clk);
			cyc(10);
			check("lower rx", 32'(lo_drv.data), 32'(ea));
			check("lower oe", 32'(lo_drv.oe), 32'(ALL_ON));
			check("upper oe", 32'(up_drv.oe), 32'(il ? MSB_ON : ALL_ON));
			check("upper rx", 32'(il ? 10'(up_drv.data[DW-1]) : up_drv.data), 32'(il ? 10'h0 : eb));
			@(negedge sample_clk);
			cyc(10);
			check("lower second", 32'(lo_drv.data), 32'(il ? eb : ea));
			if (il) check("rx marker", 32'(up_drv.data[DW-1]), 32'h1);
			@(posedge aclk);
			ea = DW'($urandom);
			eb = DW'($urandom);
			rx_a <= ea;
			rx_b <= eb;
		end
		$display("rx run done interleaved=%0d", il);
	endtask
	task automatic tx_run(input int n);
		@(posedge aclk);
		dir <= 1'b1;
		// First pair may hold a word from before the turn-around
		for (int i = 0; i <= n; i++)
		begin
			do @(negedge aclk); while (tx_word.valid !== 1'b1);
			if (i > 0)
			begin
				check("tx a", 32'(tx_word.a), 32'(cur_a));
				check("tx b", 32'(tx_word.b), 32'(cur_b));
				check("tx oe", 32'({up_drv.oe, lo_drv.oe}), 32'h0);
			end
		end
		@(posedge aclk);
		dir <= 1'b0;
		cyc(70);
		$display("tx run done");
	endtask
	initial
	begin
		#60000;
		miscompares++;
		wrap_up();
	end
	initial
	begin
		axi_req = '0;
		aresetn = 1'b0;
		strap = 1'b0;
		dir = 1'b0;
		width_sel = 1'b0;
		rx_a = '0;
		rx_b = '0;
		seed_v = $urandom(32'h88BD);
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		cyc(12);
		rd(OFS_CTRL, d, r);
		check("ctrl reset", d, 32'h0);
		rd(8'h0C, d, r);
		check("unmapped read", {d[29:0], r}, {30'h0, RESP_SLVERR});
		wr(8'h0C, 32'h1, r);
		check("unmapped write", 32'(r), 32'(RESP_SLVERR));
		wr(OFS_STATUS, 32'hFFFF_FFFF, r);
		rd(OFS_STATUS, d, r);
		check("status pins", d, 32'h4);
		rx_run(1'b0, 3);
		width_sel <= 1'b1;
		rx_run(1'b1, 3);
		width_sel <= 1'b0;
		tx_run(3);
		width_sel <= 1'b1;
		rd(OFS_TXCNT, c0, r);
		v0 = vcount;
		tx_run(4);
		rd(OFS_TXCNT, d, r);
		check("pair count", d - c0, 32'(vcount - v0));
		check("pair total", d - c0, 32'h5);
		do_reset(1'b1);
		check("fd oe", 32'({w_oe, up_drv.oe, lo_drv.oe}), {11'h400, ALL_ON});
		rd(OFS_STATUS, d, r);
		check("fd status", 32'({d[4], d[2:1]}), 32'h4);
		do_reset(1'b0);
		wr(OFS_CTRL, 32'h7, r);
		rd(OFS_STATUS, d, r);
		check("clone status", 32'({d[2:0], w_oe}), 32'hE);
		rx_run(1'b0, 2);
		tx_run(3);
		wr(OFS_CTRL, 32'hF, r);
		cyc(4);
		check("sysclk oe", 32'(w_oe), 32'h1);
		wrap_up();
	end
endmodule
